//--- design/pmc_pkg.sv
// Package for the power mode controller: constants and types
package pmc_pkg;
	localparam int unsigned CLK_PERIOD_NS       = 40;
	// Least pulse on a fast external interrupt pin
	localparam int unsigned EXT_WAKE_MIN_NS     = 40;
	localparam int unsigned EXT_WAKE_MIN_CYC    =
		((EXT_WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
		((EXT_WAKE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam int unsigned PD_VARIANT_BIT      = 5;
	localparam int unsigned NUM_FAST_EXT        = 8;
	localparam logic [7:0]  EXT_ENABLE_RST      = 8'h00;
	localparam logic [7:0]  EXT_POLARITY_RST    = 8'hff;

	typedef enum logic [4:0] {
		PMC_RUN     = 5'b0_0001,
		PMC_DRAIN   = 5'b0_0010,
		PMC_IDLE    = 5'b0_0100,
		PMC_PD_PROT = 5'b0_1000,
		PMC_PD_INT  = 5'b1_0000
	} pmc_state_e;

	typedef enum logic [1:0] {
		PMC_REQ_NONE = 2'h0,
		PMC_REQ_IDLE = 2'h1,
		PMC_REQ_PD   = 2'h2
	} pmc_req_e;
endpackage

//--- design/pmc_power_mode_controller.sv
// Power mode controller: idle, power-down entry/exit and clock reference choice
`timescale 1ns/1ns
module pmc_power_mode_controller
#(
	parameter int unsigned N_EXT = pmc_pkg::NUM_FAST_EXT
)
(
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic             i_idle_instr,
	input  wire logic             i_power_down_instruction,
	input  wire logic [15:0]      i_system_config_register,
	input  wire logic             i_regulator_off_bit,
	input  wire logic             i_bus_busy,
	input  wire logic             i_ready_enable,
	input  wire logic             i_ready_polarity,
	input  wire logic             i_ready_pin,
	input  wire logic             i_bus_access_done,
	input  wire logic             i_nmi_pin_n,
	input  wire logic [N_EXT-1:0] i_fast_ext_interrupt_pin,
	input  wire logic [N_EXT-1:0] i_fast_ext_enable,
	input  wire logic [N_EXT-1:0] i_fast_ext_active_high,
	input  wire logic             i_irq_any,
	input  wire logic             i_rtc_irq,
	input  wire logic             i_can_irq,
	input  wire logic             i_i2c_irq,
	input  wire logic             i_rtc_enable,
	input  wire logic             i_lp_osc_running,
	input  wire logic             i_lp_ref_disable,
	input  wire logic             i_return_from_interrupt_instruction,
	output logic                  o_cpu_halt,
	output logic                  o_periph_hold,
	output logic                  o_clk_stop,
	output logic                  o_wdt_hold,
	output logic                  o_main_osc_stop,
	output logic                  o_rtc_ref_lp,
	output logic                  o_rtc_run,
	output logic                  o_entry_refused,
	output logic                  o_wake_irq_service,
	output logic                  o_regulator_off_missing,
	output logic                  o_idle,
	output logic                  o_power_down
);

	typedef struct packed {
		pmc_pkg::pmc_state_e st;
		pmc_pkg::pmc_req_e   req;
		logic                variant_int;
		logic                ready_seen;
		logic                lp_ref;
		logic                refused;
		logic                wake_svc;
		logic                reg_missing;
		logic [N_EXT-1:0]    ext_meta;
		logic [N_EXT-1:0]    ext_sync;
		logic [1:0]          nmi_meta;
		logic [1:0]          lp_meta;
		logic [1:0]          rdy_meta;
	} pmc_state_s;

	pmc_state_s s_r;
	pmc_state_s s_nxt;

	logic [N_EXT-1:0] ext_active;
	logic             ext_wake;
	logic             ready_act;
	logic             entry_ok;

	// Level of a pin after polarity, so one test serves the ready pin and every fast external pin
	function automatic logic pmc_active(input logic lvl, input logic act_high);
		pmc_active = act_high ? lvl : ~lvl;
	endfunction

	always_comb
	begin
		for (int i = 0; i < N_EXT; i++)
		begin
			ext_active[i] = i_fast_ext_enable[i]
				& pmc_active(s_r.ext_sync[i], i_fast_ext_active_high[i]);
		end
		ext_wake  = |ext_active;
		ready_act = pmc_active(s_r.rdy_meta[1], i_ready_polarity);
		entry_ok  = ~i_ready_enable | s_r.ready_seen;
	end

	always_comb
	begin
		s_nxt          = s_r;
		s_nxt.refused  = 1'b0;
		s_nxt.wake_svc = 1'b0;
		s_nxt.ext_meta = i_fast_ext_interrupt_pin;
		s_nxt.ext_sync = s_r.ext_meta;
		s_nxt.nmi_meta = {s_r.nmi_meta[0], i_nmi_pin_n};
		s_nxt.lp_meta  = {s_r.lp_meta[0], i_lp_osc_running};
		s_nxt.rdy_meta = {s_r.rdy_meta[0], i_ready_pin};

		// Ready must be seen active during any bus access since reset; once seen it stays set
		if (i_bus_busy && ready_act)
		begin
			s_nxt.ready_seen = 1'b1;
		end
		else if (i_bus_access_done && !i_bus_busy)
		begin
			s_nxt.ready_seen = s_r.ready_seen;
		end
		if (i_bus_busy && !s_r.ready_seen && s_r.st == pmc_pkg::PMC_RUN)
		begin
			s_nxt.ready_seen = ready_act;
		end

		if (i_lp_ref_disable)
		begin
			s_nxt.lp_ref = 1'b0;
		end
		else if (s_r.lp_meta[1])
		begin
			s_nxt.lp_ref = 1'b1;
		end

		unique case (s_r.st)
			pmc_pkg::PMC_RUN:
			begin
				if (i_idle_instr || i_power_down_instruction)
				begin
					s_nxt.req = i_power_down_instruction ? pmc_pkg::PMC_REQ_PD
						: pmc_pkg::PMC_REQ_IDLE;
					s_nxt.variant_int =
						i_system_config_register[pmc_pkg::PD_VARIANT_BIT];
					s_nxt.reg_missing = i_power_down_instruction & ~i_regulator_off_bit;
					s_nxt.st = pmc_pkg::PMC_DRAIN;
				end
			end
			pmc_pkg::PMC_DRAIN:
			begin
				if (!i_bus_busy)
				begin
					s_nxt.st  = pmc_pkg::PMC_RUN;
					s_nxt.req = pmc_pkg::PMC_REQ_NONE;
					if (!entry_ok)
					begin
						s_nxt.refused = 1'b1;
					end
					else if (s_r.req == pmc_pkg::PMC_REQ_IDLE)
					begin
						s_nxt.st = pmc_pkg::PMC_IDLE;
					end
					else if (!s_r.variant_int)
					begin
						if (!s_r.nmi_meta[1])
						begin
							s_nxt.st = pmc_pkg::PMC_PD_PROT;
						end
						else
						begin
							s_nxt.refused = 1'b1;
						end
					end
					else
					begin
						if (!ext_wake)
						begin
							s_nxt.st = pmc_pkg::PMC_PD_INT;
						end
						else
						begin
							s_nxt.refused = 1'b1;
						end
					end
				end
			end
			pmc_pkg::PMC_IDLE:
			begin
				if (i_irq_any)
				begin
					s_nxt.st       = pmc_pkg::PMC_RUN;
					s_nxt.wake_svc = 1'b1;
				end
			end
			pmc_pkg::PMC_PD_PROT:
			begin
				s_nxt.st = pmc_pkg::PMC_PD_PROT;
			end
			pmc_pkg::PMC_PD_INT:
			begin
				if (ext_wake || i_rtc_irq || i_can_irq || i_i2c_irq)
				begin
					s_nxt.st       = pmc_pkg::PMC_RUN;
					s_nxt.wake_svc = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			s_r             <= '0;
			s_r.st          <= pmc_pkg::PMC_RUN;
			s_r.req         <= pmc_pkg::PMC_REQ_NONE;
			s_r.nmi_meta    <= 2'h3;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	logic pd;
	logic idle;
	logic return_from_interrupt_instruction_seen;

	// Outputs decode the registered state, except o_rtc_run, which follows i_rtc_enable directly
	always_comb
	begin
		pd   = (s_r.st == pmc_pkg::PMC_PD_PROT)
			|| (s_r.st == pmc_pkg::PMC_PD_INT);
		idle = (s_r.st == pmc_pkg::PMC_IDLE);

		// Interrupt return only matters to the CPU, not to the halt decode
		return_from_interrupt_instruction_seen = i_return_from_interrupt_instruction;

		o_cpu_halt    = idle | pd;

		o_periph_hold = pd;
		o_clk_stop    = pd;
		o_wdt_hold    = pd;

		// main osc stops with 32 kHz reference
		// main osc kept when it is the only reference
		o_main_osc_stop = pd & s_r.lp_ref;
		o_rtc_ref_lp    = s_r.lp_ref;

		o_rtc_run       = i_rtc_enable;

		// Single-cycle event pulses
		o_entry_refused    = s_r.refused;
		o_wake_irq_service = s_r.wake_svc;

		o_regulator_off_missing = s_r.reg_missing;

		// Mode levels
		o_idle       = idle;
		o_power_down = pd;
	end

endmodule

//--- bench/pmc_power_mode_controller_props.sv
// Checker for the power mode controller port behaviour
`timescale 1ns/1ns
module pmc_power_mode_controller_props (
	input wire logic        i_clk,
	input wire logic        i_rst,
	input wire logic [15:0] i_system_config_register,
	input wire logic        i_bus_busy,
	input wire logic        i_irq_any,
	input wire logic        i_rtc_irq,
	input wire logic        i_can_irq,
	input wire logic        i_i2c_irq,
	input wire logic        i_rtc_enable,
	input wire logic        o_cpu_halt,
	input wire logic        o_periph_hold,
	input wire logic        o_clk_stop,
	input wire logic        o_wdt_hold,
	input wire logic        o_main_osc_stop,
	input wire logic        o_rtc_ref_lp,
	input wire logic        o_rtc_run,
	input wire logic        o_entry_refused,
	input wire logic        o_wake_irq_service,
	input wire logic        o_idle,
	input wire logic        o_power_down
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_wake; !o_idle && o_wake_irq_service; endsequence
	sequence s_pd_int; o_power_down && i_system_config_register[5]; endsequence
	property p_idle_run; o_idle |-> o_cpu_halt && !o_clk_stop && !o_periph_hold; endproperty
	a_idle_run: assert property (p_idle_run) else $error("idle run");
	property p_idle_wake; o_idle && i_irq_any |=> s_wake; endproperty
	a_idle_wake: assert property (p_idle_wake) else $error("idle wake");
	property p_hold; o_power_down |-> o_clk_stop && o_wdt_hold && o_periph_hold; endproperty
	a_hold: assert property (p_hold) else $error("pd hold");
	property p_rtc; o_rtc_run == i_rtc_enable; endproperty
	a_rtc: assert property (p_rtc) else $error("rtc run");
	property p_osc; o_power_down |-> o_main_osc_stop == o_rtc_ref_lp; endproperty
	a_osc: assert property (p_osc) else $error("osc stop");
	property p_drain; $rose(o_idle) || $rose(o_power_down) |-> !$past(i_bus_busy); endproperty
	a_drain: assert property (p_drain) else $error("drain");
	property p_refuse; o_entry_refused |-> !o_idle && !o_power_down; endproperty
	a_refuse: assert property (p_refuse) else $error("refuse");
	property p_prot; o_power_down && !i_system_config_register[5] |=> o_power_down; endproperty
	a_prot: assert property (p_prot) else $error("prot");
	property p_pd_wake; s_pd_int ##0 (i_rtc_irq || i_can_irq || i_i2c_irq) |-> ##[1:3] s_wake;
	endproperty
	a_pd_wake: assert property (p_pd_wake) else $error("pd wake");
endmodule
bind pmc_power_mode_controller pmc_power_mode_controller_props props_u (.*);

//--- bench/pmc_wake_src_model.sv
// Partner model: outside party driving the fast external interrupt pins
`timescale 1ns/1ns
module pmc_wake_src_model (
	input  wire logic       i_clk,
	input  wire logic       i_fire,
	input  wire logic [2:0] i_sel,
	input  wire logic       i_hold,
	output logic      [7:0] o_pins
);
	logic [7:0] pulse = 8'h00;
	assign o_pins = pulse | {8{i_hold}};
	always @(posedge i_clk)
		if (i_fire)
		begin
			#1 pulse = 8'h01 << i_sel;
			repeat (2) @(posedge i_clk);
			#1 pulse = 8'h00;
		end
endmodule

//--- bench/test_pmc_power_mode_controller.sv
// Testbench for the power mode controller
`timescale 1ns/1ns
module test_pmc_power_mode_controller;
	logic i_clk, i_rst, i_idle_instr, i_power_down_instruction, i_regulator_off_bit, i_bus_busy;
	logic i_ready_enable, i_ready_polarity, i_ready_pin, i_bus_access_done, i_nmi_pin_n;
	logic i_irq_any, i_rtc_irq, i_can_irq, i_i2c_irq, i_rtc_enable, i_lp_osc_running;
	logic i_lp_ref_disable, i_return_from_interrupt_instruction, fire, hold, pi, pp;
	logic [15:0] i_system_config_register;
	logic [7:0] i_fast_ext_interrupt_pin, i_fast_ext_enable, i_fast_ext_active_high;
	logic o_cpu_halt, o_periph_hold, o_clk_stop, o_wdt_hold, o_main_osc_stop, o_rtc_ref_lp;
	logic o_rtc_run, o_entry_refused, o_wake_irq_service, o_regulator_off_missing, o_idle;
	logic o_power_down;
	logic [2:0] sel;
	logic [3:0] exp_q[$];
	logic [3:0] ev, ex;
	int error_cnt = 0, check_count = 0, cyc = 0, seed;
	pmc_power_mode_controller dut_u (.*);
	pmc_wake_src_model wake_u (.i_clk(i_clk), .i_fire(fire), .i_sel(sel), .i_hold(hold),
		.o_pins(i_fast_ext_interrupt_pin));
	task automatic chk(input string nm, input logic [3:0] s, input logic [3:0] e);
		check_count++;
		if (s !== e)
		begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic req(input logic pd, input logic [3:0] e);
		{i_idle_instr, i_power_down_instruction} = {!pd, pd};
		exp_q.push_back(e);
		tick(1);
		{i_idle_instr, i_power_down_instruction} = 2'h0;
		tick(4);
	endtask
	task automatic results;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		i_clk = 0;
		forever #20 i_clk = ~i_clk;
	end
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			error_cnt++;
			results();
		end
	end
	always @(posedge i_clk)
	begin
		#2;
		if ((o_idle && !pi) || (o_power_down && !pp) || o_entry_refused || o_wake_irq_service)
		begin
			ev = {o_idle, o_power_down, o_entry_refused, o_wake_irq_service};
			ex = exp_q.size() ? exp_q.pop_front() : 4'hf;
			chk("event", ev, ex);
		end
		{pi, pp} = {o_idle, o_power_down};
	end
	initial
	begin
		{i_idle_instr, i_power_down_instruction, i_regulator_off_bit, i_bus_busy} = 4'h0;
		{i_ready_enable, i_ready_polarity, i_nmi_pin_n, i_rst, i_lp_ref_disable} = 5'h1f;
		{i_ready_pin, i_bus_access_done, i_irq_any, i_rtc_irq, i_can_irq} = 5'h00;
		{i_i2c_irq, i_rtc_enable, i_lp_osc_running, fire, hold, pi, pp} = 7'h00;
		{i_return_from_interrupt_instruction, sel} = 4'h0;
		{i_fast_ext_enable, i_fast_ext_active_high} = 16'hffff;
		i_system_config_register = 16'h0000;
		seed = 32'h0000_a0ba;
		tick(20);
		i_rst = 0;
		tick(3);
		i_bus_busy = 1;
		tick(2);
		i_bus_busy = 0;
		req(0, 4'h2);
		$display("test refusal done");
		{i_ready_pin, i_bus_busy} = 2'h3;
		tick(3);
		req(0, 4'h8);
		chk("drain", 4'(o_idle), 4'h0);
		i_bus_busy = 0;
		tick(4);
		exp_q.push_back(4'h1);
		i_irq_any = 1;
		tick(1);
		{i_irq_any, i_ready_enable} = 2'h0;
		tick(3);
		$display("test idle done");
		i_system_config_register = 16'($random(seed)) & 16'hffdf;
		req(1, 4'h2);
		chk("regoff", 4'(o_regulator_off_missing), 4'h1);
		{i_nmi_pin_n, i_regulator_off_bit} = 2'h1;
		tick(3);
		req(1, 4'h4);
		chk("hold", 4'({o_clk_stop, o_wdt_hold, o_periph_hold}), 4'h7);
		{i_irq_any, i_rtc_irq, i_can_irq, i_i2c_irq, fire} = 5'h1f;
		tick(1);
		{i_irq_any, i_rtc_irq, i_can_irq, i_i2c_irq, fire} = 5'h00;
		tick(6);
		chk("prot", 4'(o_power_down), 4'h1);
		i_rst = 1;
		tick(2); // held in reset
		{i_rst, i_nmi_pin_n} = 2'h1;
		tick(3);
		chk("exit", 4'(o_power_down), 4'h0);
		$display("test protected done");
		i_system_config_register = 16'($random(seed)) | 16'h0020;
		hold = 1;
		tick(4);
		req(1, 4'h2);
		hold = 0;
		for (int k = 0; k < 4; k++)
		begin
			{i_lp_osc_running, i_lp_ref_disable} = {k[0], !k[0]};
			i_rtc_enable = 1'($random(seed));
			sel = 3'($random(seed));
			tick(4);
			req(1, 4'h4);
			chk("ref", 4'(o_rtc_ref_lp), 4'(k[0]));
			chk("osc", 4'(o_main_osc_stop), 4'(k[0]));
			exp_q.push_back(4'h1);
			{fire, i_rtc_irq, i_can_irq, i_i2c_irq} = 4'h8 >> k;
			tick(1);
			{fire, i_rtc_irq, i_can_irq, i_i2c_irq} = 4'h0;
			tick(6);
		end
		$display("test interruptible done");
		chk("queue", 4'(exp_q.size()), 4'h0);
		results();
	end
endmodule
